// ### hw/host_port_irq_timers.sv
`timescale 1ns/10ps
`default_nettype none
module host_port_irq_timers
    import host_port_irq_timers_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_DIV
)
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    // straps
    input  wire logic       i_bus_style_strap,
    input  wire logic       i_bus_multiplex_strap,
    // host bus
    input  wire logic       i_ale,
    input  wire logic       i_cs_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    input  wire logic       i_data_strobe_n,
    input  wire logic       i_rw_n,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_ad,
    output logic      [7:0] o_ad,
    output logic            o_ad_oe,
    output logic            o_ready_n,
    // interrupt request, open drain
    output logic            o_irq_n,
    output logic            o_irq_oe,
    // symbol clock enable and alarm conditions
    input  wire logic       i_symbol_tick,
    input  wire logic [3:0] i_alarm,
    // timer expiry strobes for the meters, and the inactive mode bit
    output logic            o_snr_interval,
    output logic            o_meter_interval,
    output logic            o_mode_inactive
);
    localparam int PW = $clog2(PRESCALE);

    typedef struct packed {
        logic [1:0]                  rst_sync;
        logic                        ale_d;
        logic                        rd_act_d;
        logic                        wr_act_d;
        logic [7:0]                  addr;
        logic [7:0]                  wdata;
        logic [7:0]                  mode_reg;
        logic [7:0]                  en_low;
        logic [7:0]                  en_high;
        logic [7:0]                  cd_cause;
        logic [7:0]                  alarm_cause;
        logic [7:0]                  cd_run;
        logic [7:0]                  cd_auto;
        logic [NUM_TIMERS-1:0][15:0] interval;
        logic [NUM_TIMERS-1:0][15:0] count;
        logic [NUM_TIMERS-1:0]       expired;
        logic [PW-1:0]               prescale;
        logic [7:0]                  rdata;
        logic                        ad_oe;
        logic                        irq_oe;
        logic                        snr_iv;
        logic                        meter_iv;
        logic                        ready_n;
        logic                        irq_level;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // interval bytes live in one 16-byte window, decoded for reads and writes alike
    function automatic logic in_interval_window(input logic [7:0] a);
        return (a >= ADDR_INTERVAL_BASE) && (a < ADDR_INTERVAL_BASE + 8'h10);
    endfunction : in_interval_window

    // one strobe decode for both directions; the style strap picks the pins that count
    function automatic logic bus_active(
        input logic style,
        input logic cs_n,
        input logic plain_n,
        input logic ds_n,
        input logic rw_match
    );
        logic act;
        act = 1'b0;
        if (!cs_n)
        begin
            act = style ? (!ds_n && rw_match) : !plain_n;
        end
        return act;
    endfunction : bus_active

    // only the step from one to zero is a time-out; a counter already at zero
    // is holding, and must not report again
    function automatic logic timer_due(input logic [15:0] c);
        return c == 16'h0001;
    endfunction : timer_due

    function automatic logic [7:0] read_mux(input state_s s, input logic [7:0] a);
        logic [7:0] v;
        v = BYTE_ZERO;
        case (a)
            ADDR_GLOBAL_MODE:
            begin
                v = s.mode_reg;
            end
            ADDR_IRQ_EN_LOW:
            begin
                v = s.en_low;
            end
            ADDR_IRQ_EN_HIGH:
            begin
                v = {4'h0, s.en_high[3:0]};
            end
            ADDR_CD_CAUSE:
            begin
                v = s.cd_cause;
            end
            ADDR_ALARM_CAUSE:
            begin
                v = {4'h0, s.alarm_cause[3:0]};
            end
            ADDR_CD_RUN:
            begin
                v = s.cd_run;
            end
            ADDR_CD_AUTO:
            begin
                v = s.cd_auto;
            end
            default:
            begin
                // unassigned addresses read zero, host is told not to rely on it
                if (in_interval_window(a))
                begin
                    v = a[0] ? s.interval[a[3:1]][15:8] : s.interval[a[3:1]][7:0];
                end
            end
        endcase
        return v;
    endfunction : read_mux

    logic       rst_n;
    logic       style_hi;
    logic       rd_act;
    logic       wr_act;
    logic [7:0] lat_addr;

    assign rst_n    = st_ff.rst_sync[1];
    assign style_hi = i_bus_style_strap;
    // strap selects strobe style; direction line qualifies the data strobe
    assign rd_act = bus_active(style_hi, i_cs_n, i_rd_n, i_data_strobe_n, i_rw_n);
    assign wr_act = bus_active(style_hi, i_cs_n, i_wr_n, i_data_strobe_n, !i_rw_n);
    assign lat_addr = i_bus_multiplex_strap ? i_ad : i_addr;

    always_comb
    begin
        logic       tick_pre;
        logic       tick;
        logic [7:0] fire;
        logic       wstrobe;
        logic       cd_pending;
        logic       alarm_pending;
        nxt_st       = st_ff;
        tick_pre     = 1'b0;
        tick         = 1'b0;
        fire         = BYTE_ZERO;
        wstrobe      = 1'b0;
        cd_pending   = 1'b0;
        alarm_pending = 1'b0;
        nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
        nxt_st.ale_d    = i_ale;
        nxt_st.rd_act_d = rd_act;
        nxt_st.wr_act_d = wr_act;
        nxt_st.snr_iv   = 1'b0;
        nxt_st.meter_iv = 1'b0;

        if (st_ff.ale_d && !i_ale)
        begin
            nxt_st.addr = lat_addr;
        end
        if (wr_act)
        begin
            nxt_st.wdata = i_ad;
        end
        // a write acts as the strobe rises, with the byte seen in its last active cycle
        wstrobe = st_ff.wr_act_d && !wr_act;

        // drive while strobe active, release on its rise
        nxt_st.ad_oe = rd_act;
        // busy for the one cycle in which the read byte is fetched
        nxt_st.ready_n = rd_act && !st_ff.rd_act_d;
        if (rd_act && !st_ff.rd_act_d)
        begin
            nxt_st.rdata = read_mux(st_ff, st_ff.addr);
        end

        // startup timers trade resolution for span: they step once per prescaler wrap
        // shared prescaler, the rest run at symbol rate
        if (i_symbol_tick)
        begin
            tick = 1'b1;
            if (st_ff.prescale == PW'(PRESCALE - 1))
            begin
                nxt_st.prescale = '0;
                tick_pre = 1'b1;
            end
            else
            begin
                nxt_st.prescale = st_ff.prescale + 1'b1;
            end
        end

        for (int k = 0; k < NUM_TIMERS; k++)
        begin
            logic step;
            step = (k < NUM_STARTUP) ? tick_pre : tick;
            if (st_ff.cd_run[k] && step && !st_ff.expired[k])
            begin
                if (timer_due(st_ff.count[k]))
                begin
                    fire[k] = 1'b1;
                    if (st_ff.cd_auto[k])
                    begin
                        nxt_st.count[k] = st_ff.interval[k];
                    end
                    else
                    begin
                        nxt_st.count[k]   = 16'h0000;
                        nxt_st.expired[k] = 1'b1;
                    end
                end
                else if (st_ff.count[k] != 16'h0000)
                begin
                    nxt_st.count[k] = st_ff.count[k] - 16'h0001;
                end
            end
        end
        nxt_st.meter_iv = fire[4];
        nxt_st.snr_iv   = fire[5];

        if (wstrobe)
        begin
            case (st_ff.addr)
                ADDR_GLOBAL_MODE:
                begin
                    nxt_st.mode_reg = st_ff.wdata;
                end
                ADDR_IRQ_EN_LOW:
                begin
                    nxt_st.en_low = st_ff.wdata;
                end
                ADDR_IRQ_EN_HIGH:
                begin
                    nxt_st.en_high = st_ff.wdata;
                end
                ADDR_CD_CAUSE:
                begin
                    nxt_st.cd_cause = st_ff.cd_cause & st_ff.wdata;
                end
                ADDR_ALARM_CAUSE:
                begin
                    nxt_st.alarm_cause = st_ff.alarm_cause & st_ff.wdata;
                end
                ADDR_CD_RUN:
                begin
                    nxt_st.cd_run = st_ff.wdata;
                end
                ADDR_CD_AUTO:
                begin
                    nxt_st.cd_auto = st_ff.wdata;
                end
                ADDR_CD_RELOAD:
                begin
                    for (int k = 0; k < NUM_TIMERS; k++)
                    begin
                        if (st_ff.wdata[k])
                        begin
                            nxt_st.count[k]   = st_ff.interval[k];
                            nxt_st.expired[k] = 1'b0;
                        end
                    end
                end
                default:
                begin
                    if (in_interval_window(st_ff.addr))
                    begin
                        if (st_ff.addr[0])
                        begin
                            nxt_st.interval[st_ff.addr[3:1]][15:8] = st_ff.wdata;
                        end
                        else
                        begin
                            nxt_st.interval[st_ff.addr[3:1]][7:0] = st_ff.wdata;
                        end
                    end
                end
            endcase
        end

        // sets win over a clear in the same cycle
        nxt_st.cd_cause = nxt_st.cd_cause | fire;
        nxt_st.alarm_cause[3:0] = nxt_st.alarm_cause[3:0] | i_alarm;

        // the mask gates only the request; cause bits still record masked events
        cd_pending    = |(nxt_st.cd_cause & nxt_st.en_low);
        alarm_pending = |(nxt_st.alarm_cause[3:0] & nxt_st.en_high[3:0]);
        // open drain: enable only to pull low
        nxt_st.irq_oe = cd_pending || alarm_pending;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            // everything but the mode bit is cleared too, so no register starts unknown
            st_ff <= '0;
            st_ff.mode_reg[MODE_BIT] <= MODE_RESET;
            st_ff.ale_d <= 1'b0;
        end
        else if (!rst_n)
        begin
            st_ff          <= '0;
            st_ff.rst_sync <= nxt_st.rst_sync;
            st_ff.mode_reg[MODE_BIT] <= MODE_RESET;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_ad             = st_ff.rdata;
    assign o_ad_oe          = st_ff.ad_oe;
    assign o_ready_n        = st_ff.ready_n;
    // open drain: the pin level is a flop held low, only the enable moves
    assign o_irq_n          = st_ff.irq_level;
    assign o_irq_oe         = st_ff.irq_oe;
    assign o_snr_interval   = st_ff.snr_iv;
    assign o_meter_interval = st_ff.meter_iv;
    assign o_mode_inactive  = st_ff.mode_reg[MODE_BIT];
endmodule : host_port_irq_timers
`default_nettype wire

// ### hw/host_port_irq_timers_pkg.sv
// Notes on behaviour
// - Register address is captured when the address latch strobe falls.
// - Read data is driven once chip select and read or data strobe are low.
// - Read ends when chip select or strobe rises; bus is then released.
// - Write data is captured on the rising edge of write or data strobe.
// - Twelve sources share one active-low interrupt request output.
// - Each source is enabled by its bit in mask registers 0x02 and 0x03.
// - Cause registers 0x04 and 0x05 report which sources interrupted.
// - Timer status sets only on the transition of its counter to zero.
// - Alarm status cannot be cleared while its alarm condition persists.
// - Interrupt output only pulls low or floats, open drain.
// - Reset sets mode bit 0 of register 0x00, inactive state.
// - Eight down counters with zero detect, loaded from 16-bit interval pairs.
// - Writing one to a restart bit at 0x0C reloads that timer.
// - A timer counts only while its enable bit at 0x0D is one.
// - Continuous bit at 0x0E reloads the interval after reaching zero.
// - Each time-out produces exactly one edge-triggered interrupt event.
// - Four startup timers share one divide-by-1024 prescaler of the symbol clock.
// - Snr, meter and general timers decrement once per symbol period.
// - Snr timer times the low-snr meter; meter timer times all others.
// - Straps select strobe style and multiplexed or separate address bus.
// - Active-low ready output signals when a transfer can complete.
package host_port_irq_timers_pkg;
    localparam logic [7:0]  ADDR_GLOBAL_MODE   = 8'h00;
    localparam logic [7:0]  ADDR_IRQ_EN_LOW    = 8'h02;
    localparam logic [7:0]  ADDR_IRQ_EN_HIGH   = 8'h03;
    localparam logic [7:0]  ADDR_CD_CAUSE      = 8'h04;
    localparam logic [7:0]  ADDR_ALARM_CAUSE   = 8'h05;
    localparam logic [7:0]  ADDR_CD_RELOAD     = 8'h0C;
    localparam logic [7:0]  ADDR_CD_RUN        = 8'h0D;
    localparam logic [7:0]  ADDR_CD_AUTO       = 8'h0E;
    // interval pairs: timer k low byte at base+2k, high byte at base+2k+1
    localparam logic [7:0]  ADDR_INTERVAL_BASE = 8'h10;
    localparam int          MODE_BIT           = 0;
    localparam logic        MODE_RESET         = 1'b1;
    localparam int          NUM_TIMERS         = 8;
    localparam int          NUM_STARTUP        = 4;
    localparam int          NUM_ALARMS         = 4;
    localparam int          PRESCALE_DIV       = 1024;
    localparam logic [7:0]  BYTE_ZERO          = 8'h00;
endpackage : host_port_irq_timers_pkg

// ### verification/host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
    // straps and clock
    input  wire logic       i_clk,
    input  wire logic       i_style,
    input  wire logic       i_mux,
    // device side of the shared bus
    input  wire logic [7:0] i_ad,
    input  wire logic       i_ad_oe,
    // host drive
    output logic            o_ale,
    output logic            o_cs_n,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic            o_ds_n,
    output logic            o_rw_n,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_ad
);
    logic [7:0] drv;
    // the device wins the wire while it drives; otherwise the host's own pattern drv
    assign o_ad = i_ad_oe ? i_ad : drv;
    initial
    begin
        {o_ale, o_cs_n, o_rd_n, o_wr_n, o_ds_n, o_rw_n} = 6'h1f;
        drv = 8'h5a;
        o_addr = 8'ha5;
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_ale <= 1'h1;
        drv <= i_mux ? a : ~a;
        o_addr <= i_mux ? ~a : a;
        @(negedge i_clk);
        o_ale <= 1'h0;
        @(negedge i_clk);
        o_rw_n <= ~w;
        drv <= w ? d : ~drv;
        @(negedge i_clk);
        o_cs_n <= 1'h0;
        o_ds_n <= ~i_style;
        o_wr_n <= ~(w & ~i_style);
        o_rd_n <= ~(~w & ~i_style);
        repeat (3) @(negedge i_clk);
        {o_cs_n, o_rd_n, o_wr_n, o_ds_n} <= 4'hf;
        @(negedge i_clk);
        o_rw_n <= 1'h1;
        drv <= ~drv;
        repeat (2) @(negedge i_clk);
    endtask : acc
endmodule : host_bus_model
`default_nettype wire

// ### verification/host_port_irq_timers_props.sv
`timescale 1ns/10ps
`default_nettype none
module host_port_irq_timers_props #(
    parameter int PRESCALE = 1024
)
(
    // bus inputs
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_bus_style_strap,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_data_strobe_n,
    input wire logic i_rw_n,
    input wire logic i_symbol_tick,
    // outputs
    input wire logic o_ad_oe,
    input wire logic o_ready_n,
    input wire logic o_irq_n,
    input wire logic o_snr_interval,
    input wire logic o_meter_interval,
    input wire logic o_mode_inactive
);
    logic rd_act;
    logic wr_act;
    assign rd_act = !i_cs_n && (i_bus_style_strap ? !i_data_strobe_n && i_rw_n : !i_rd_n);
    assign wr_act = !i_cs_n && (i_bus_style_strap ? !i_data_strobe_n && !i_rw_n : !i_wr_n);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    property p_irq_low; o_irq_n == 1'h0; endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq pin driven high");
    property p_mode_rst; $rose(i_arst_n) |-> o_mode_inactive; endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("mode bit clear at reset");
    property p_rd_drive; rd_act [*3] |-> o_ad_oe; endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
    property p_rd_free; !rd_act [*3] |-> !o_ad_oe; endproperty
    a_rd_free: assert property (p_rd_free) else $error("bus held after read");
    property p_wr_quiet; wr_act |-> !o_ad_oe; endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("bus driven in write");
    property p_ready; o_ready_n |=> !o_ready_n; endproperty
    a_ready: assert property (p_ready) else $error("ready held off too long");
    property p_meter; o_meter_interval |-> $past(i_symbol_tick) || $past(i_symbol_tick, 2);
    endproperty
    a_meter: assert property (p_meter) else $error("meter expiry without tick");
    property p_snr; o_snr_interval |-> $past(i_symbol_tick) || $past(i_symbol_tick, 2);
    endproperty
    a_snr: assert property (p_snr) else $error("snr expiry without tick");
endmodule : host_port_irq_timers_props
bind host_port_irq_timers host_port_irq_timers_props #(.PRESCALE(PRESCALE)) u_props (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_bus_style_strap(i_bus_style_strap),
    .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_data_strobe_n(i_data_strobe_n),
    .i_rw_n(i_rw_n), .i_symbol_tick(i_symbol_tick), .o_ad_oe(o_ad_oe),
    .o_ready_n(o_ready_n), .o_irq_n(o_irq_n), .o_snr_interval(o_snr_interval),
    .o_meter_interval(o_meter_interval), .o_mode_inactive(o_mode_inactive));
`default_nettype wire

// ### verification/host_port_irq_timers_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module host_port_irq_timers_tb_top;
    import host_port_irq_timers_pkg::*;
    logic       clk = 1'h0;
    logic       arst_n, style, mux, tick, ale, cs_n, rd_n, wr_n, ds_n, rw_n;
    logic       oe, rdy_n, irq_n, irq_oe, inactive, oe_d;
    logic [7:0] addr, ad, ad_out, d;
    logic [3:0] alarm;
    logic [7:0] expq[$];
    int         num_errors = 0, tests_run = 0, cyc = 0;
    int         tmr[4] = '{0, 4, 5, 7};
    integer     seed = 32'h652e_3ea7;
    always #12.5 clk = ~clk;
    host_port_irq_timers #(.PRESCALE(4)) DUT (.i_clk(clk), .i_arst_n(arst_n),
        .i_bus_style_strap(style), .i_bus_multiplex_strap(mux), .i_ale(ale), .i_cs_n(cs_n),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data_strobe_n(ds_n), .i_rw_n(rw_n), .i_addr(addr),
        .i_ad(ad), .o_ad(ad_out), .o_ad_oe(oe), .o_ready_n(rdy_n), .o_irq_n(irq_n),
        .o_irq_oe(irq_oe), .i_symbol_tick(tick), .i_alarm(alarm), .o_snr_interval(),
        .o_meter_interval(), .o_mode_inactive(inactive));
    host_bus_model u_host (.i_clk(clk), .i_style(style), .i_mux(mux), .i_ad(ad_out),
        .i_ad_oe(oe), .o_ale(ale), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .o_ds_n(ds_n), .o_rw_n(rw_n), .o_addr(addr), .o_ad(ad));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        u_host.acc(1'h1, a, v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        u_host.acc(1'h0, a, 8'h00);
    endtask : rd
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    // read results are taken on the first falling edge after the device starts driving
    always @(negedge clk)
    begin
        oe_d <= oe;
        tick <= (cyc % 4 == 0);
        if (oe === 1'h1 && oe_d === 1'h0)
        begin
            chk("ready busy", 8'h01, {7'h00, rdy_n});
            if (expq.size() > 0)
                chk("read data", expq.pop_front(), ad_out);
            else
                chk("spurious read", 8'h00, 8'hff);
        end
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            num_errors++;
            conclude();
        end
    end
    initial
    begin
        {arst_n, alarm, style, mux} = 7'h01;
        repeat (4) @(negedge clk);
        arst_n = 1'h1;
        repeat (3) @(negedge clk);
        chk("mode bit", 8'h01, {7'h00, inactive});
        rd(ADDR_GLOBAL_MODE, 8'h01);
        rd(ADDR_CD_CAUSE, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($random(seed));
            {style, mux} = 2'(i);
            wr(ADDR_IRQ_EN_LOW, d);
            rd(ADDR_IRQ_EN_LOW, d);
        end
        {style, mux} = 2'h1;
        wr(8'h07, d);
        rd(8'h07, 8'h00);
        wr(ADDR_GLOBAL_MODE, 8'h00);
        chk("mode bit", 8'h00, {7'h00, inactive});
        foreach (tmr[i])
        begin
            wr(ADDR_INTERVAL_BASE + 8'(2 * tmr[i]), 8'h03);
            wr(ADDR_INTERVAL_BASE + 8'(2 * tmr[i] + 1), 8'h00);
        end
        wr(ADDR_IRQ_EN_LOW, 8'h80);
        wr(ADDR_CD_AUTO, 8'h10);
        wr(ADDR_CD_RELOAD, 8'hb1);
        wr(ADDR_CD_RUN, 8'hb1);
        // three symbol ticks for the unscaled timers, far short of the prescaled one
        repeat (12) @(negedge clk);
        rd(ADDR_CD_CAUSE, 8'hb0);
        chk("irq drive", 8'h01, {7'h00, irq_oe});
        repeat (60) @(negedge clk);
        rd(ADDR_CD_CAUSE, 8'hb1);
        wr(ADDR_IRQ_EN_LOW, 8'h00);
        chk("irq masked", 8'h00, {7'h00, irq_oe});
        wr(ADDR_CD_CAUSE, 8'h00);
        repeat (20) @(negedge clk);
        rd(ADDR_CD_CAUSE, 8'h10);
        alarm = 4'h1;
        wr(ADDR_IRQ_EN_HIGH, 8'h01);
        chk("alarm irq", 8'h01, {7'h00, irq_oe});
        wr(ADDR_ALARM_CAUSE, 8'h00);
        rd(ADDR_ALARM_CAUSE, 8'h01);
        alarm = 4'h0;
        wr(ADDR_ALARM_CAUSE, 8'h00);
        rd(ADDR_ALARM_CAUSE, 8'h00);
        conclude();
    end
endmodule : host_port_irq_timers_tb_top
`default_nettype wire
